// ### core/flash_spi_pkg.sv
// Purpose: Shared constants for the serial flash SPI front end.
// Assumes: Serial pins are sampled by the 200 MHz REF_CLK domain.
// Notes:   Opcodes and status field positions are named here once.
`default_nettype none

package flash_spi_pkg;

  // ****************************************************************
  // Command and byte framing
  // ****************************************************************
  localparam int          BYTE_BITS       = 8;
  localparam logic [7:0]  OP_STATUS_WRITE = 8'h01;
  localparam logic [2:0]  BYTE_OPCODE     = 3'h0;
  localparam logic [2:0]  BYTE_STATUS     = 3'h1;
  localparam logic [2:0]  BYTE_ADDR_LAST  = 3'h3;
  localparam logic [2:0]  BIT_LAST        = 3'h7;

  // ****************************************************************
  // Status register fields and reset value
  // ****************************************************************
  localparam int          ST_BUSY         = 0;
  localparam int          ST_WEL          = 1;
  localparam int          ST_LEVEL_LO     = 2;
  localparam int          ST_LEVEL_HI     = 5;
  localparam int          ST_AAI          = 6;
  localparam int          ST_LOCK         = 7;
  localparam logic [3:0]  LEVEL_RESET     = 4'h7;
  localparam logic        LOCK_RESET      = 1'b0;

  // ****************************************************************
  // Array organisation
  // ****************************************************************
  localparam logic [23:0] SECTOR_MASK     = 24'hFFF000;
  localparam logic [23:0] BLOCK32_MASK    = 24'hFF8000;
  localparam logic [23:0] BLOCK64_MASK    = 24'hFF0000;
  localparam logic [23:0] ARRAY_TOP_SPAN  = 24'h010000;

endpackage : flash_spi_pkg

`default_nettype wire

// ### core/pause_if.sv
// Purpose: Carries pause handshake signals between the front end and its pause tracker.
// Assumes: All signals belong to the REF_CLK domain.
// Notes:   Core side drives synced pin levels, tracker returns the pause state.
`default_nettype none

interface pause_if;
  logic sck_low;
  logic cs_active;
  logic hold_level;
  logic paused;

  modport tracker (input sck_low, input cs_active, input hold_level, output paused);
  modport core    (output sck_low, output cs_active, output hold_level, input paused);
endinterface : pause_if

`default_nettype wire

// ### core/pause_tracker.sv
// Purpose: Tracks entry and exit of the pause state against the serial clock.
// Assumes: Inputs are already synchronised to REF_CLK.
// Notes:   A pause edge seen with the clock high takes effect once it goes low.
`default_nettype none

module pause_tracker (
  input  wire logic REF_CLK,
  input  wire logic RST_N,
  pause_if.tracker  pif
);

  // Deselected with the pause pin high is standby at any clock level; while selected,
  // pause follows the pause level only when the serial clock is low.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pif.paused <= 1'b0;
    end else if (pif.hold_level && !pif.cs_active) begin
      pif.paused <= 1'b0;
    end else if (pif.sck_low && pif.cs_active) begin
      pif.paused <= !pif.hold_level;
    end
  end

endmodule : pause_tracker

`default_nettype wire

// ### core/serial_flash_spi_front_end.sv
// Purpose: Serial interface front end of an SPI flash: framing, shifting, pause,
//          ready/busy output and status register write protection.
// Assumes: SCK, CE_N, SI, HOLD_N and WP_N are asynchronous to REF_CLK and slow
//          enough for REF_CLK to see every level.
// Notes:   Data-out is split into level and active-low enable; the pad joins them.
`default_nettype none

module serial_flash_spi_front_end
  import flash_spi_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        SCK,
  input  wire logic        CE_N,
  input  wire logic        SI,
  input  wire logic        HOLD_N,
  input  wire logic        WP_N,
  input  wire logic [7:0]  TX_DATA,
  input  wire logic        TX_ENABLE,
  input  wire logic        RYBY_ENABLE,
  input  wire logic        AAI_ACTIVE,
  input  wire logic        BUSY_IN,
  input  wire logic        WEL_IN,
  output logic             SO_OUT,
  output logic             SO_OE_N,
  output logic [7:0]       RX_DATA,
  output logic             RX_VALID,
  output logic [2:0]       RX_INDEX,
  output logic             FRAME_START,
  output logic             FRAME_END,
  output logic             FRAME_ABORT,
  output logic             STATUS_WRITE_DONE,
  output logic             STATUS_WRITE_REJECT,
  output logic [7:0]       STATUS_REG,
  output logic [23:0]      ADDR,
  output logic [23:0]      SECTOR_BASE,
  output logic [23:0]      BLOCK32_BASE,
  output logic [23:0]      BLOCK64_BASE,
  output logic             ADDR_PROTECTED,
  output logic             PAUSED
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic       sck_prev;
  logic       cs_prev;

  // Two flops per pin; only the second stage is read by logic.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      sync1 <= 5'h1E;
      sync2 <= 5'h1E;
    end else begin
      sync1 <= {WP_N, HOLD_N, CE_N, SI, SCK};
      sync2 <= sync1;
    end
  end

  logic sck_s;
  logic si_s;
  logic cs_n_s;
  logic hold_s;
  logic wp_s;
  assign sck_s  = sync2[0];
  assign si_s   = sync2[1];
  assign cs_n_s = sync2[2];
  assign hold_s = sync2[3];
  assign wp_s   = sync2[4];

  // Previous levels for edge detection.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      sck_prev <= 1'b0;
      cs_prev  <= 1'b1;
    end else begin
      sck_prev <= sck_s;
      cs_prev  <= cs_n_s;
    end
  end

  // ****************************************************************
  // Pause tracking
  // ****************************************************************
  pause_if pif ();

  assign pif.sck_low    = !sck_s;
  assign pif.cs_active  = !cs_n_s;
  assign pif.hold_level = hold_s;

  pause_tracker u_pause (
    .REF_CLK (REF_CLK),
    .RST_N   (RST_N),
    .pif     (pif)
  );

  logic selected;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  assign selected = !cs_n_s && !pif.paused;
  assign sck_rise = selected && sck_s && !sck_prev;
  assign sck_fall = selected && !sck_s && sck_prev;
  assign cs_fall  = !cs_n_s && cs_prev;
  assign cs_rise  = cs_n_s && !cs_prev;

  // ****************************************************************
  // Receive shifter
  // ****************************************************************
  logic [2:0] bit_pos;
  logic [6:0] rx_shift;
  logic [2:0] byte_cnt;
  logic [7:0] opcode;
  logic [7:0] status_data;
  logic [7:0] next_byte;
  logic       byte_done;
  assign next_byte = {rx_shift, si_s};
  assign byte_done = sck_rise && (bit_pos == BIT_LAST);

  // Bit position advances on rising edges only; pause holds it as is.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      bit_pos  <= 3'h0;
      rx_shift <= 7'h00;
    end else if (cs_n_s || cs_fall) begin
      bit_pos  <= 3'h0;
      rx_shift <= 7'h00;
    end else if (sck_rise) begin
      bit_pos  <= bit_pos + 3'h1;
      rx_shift <= next_byte[6:0];
    end
  end

  // Byte counter, captured opcode and status data of the frame.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      byte_cnt    <= 3'h0;
      opcode      <= 8'h00;
      status_data <= 8'h00;
    end else if (cs_n_s) begin
      byte_cnt <= 3'h0;
    end else if (byte_done) begin
      if (byte_cnt != 3'h7) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
      if (byte_cnt == BYTE_OPCODE) begin
        opcode <= next_byte;
      end
      if (byte_cnt == BYTE_STATUS) begin
        status_data <= next_byte;
      end
    end
  end

  // Received byte handed to the command core.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      RX_DATA  <= 8'h00;
      RX_VALID <= 1'b0;
      RX_INDEX <= 3'h0;
    end else begin
      RX_VALID <= byte_done;
      if (byte_done) begin
        RX_DATA  <= next_byte;
        RX_INDEX <= byte_cnt;
      end
    end
  end

  // Frame events: start on select fall, abort if a byte is cut short.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      FRAME_START <= 1'b0;
      FRAME_END   <= 1'b0;
      FRAME_ABORT <= 1'b0;
    end else begin
      FRAME_START <= cs_fall;
      FRAME_END   <= cs_rise && (bit_pos == 3'h0);
      FRAME_ABORT <= cs_rise && (bit_pos != 3'h0);
    end
  end

  // ****************************************************************
  // Address capture and array decoding
  // ****************************************************************
  // Address bytes arrive most significant first after the opcode.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ADDR <= 24'h000000;
    end else if (byte_done && byte_cnt != BYTE_OPCODE && byte_cnt <= BYTE_ADDR_LAST) begin
      ADDR <= {ADDR[15:0], next_byte};
    end
  end

  // Erase base addresses of the sector and both overlay blocks.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      SECTOR_BASE  <= 24'h000000;
      BLOCK32_BASE <= 24'h000000;
      BLOCK64_BASE <= 24'h000000;
    end else begin
      SECTOR_BASE  <= ADDR & SECTOR_MASK;
      BLOCK32_BASE <= ADDR & BLOCK32_MASK;
      BLOCK64_BASE <= ADDR & BLOCK64_MASK;
    end
  end

  // ****************************************************************
  // Status register and write protection
  // ****************************************************************
  logic [3:0]  level;
  logic        lock;
  logic        sw_hit;
  logic        sw_allow;
  assign sw_hit   = cs_rise && (bit_pos == 3'h0) && (opcode == OP_STATUS_WRITE)
                    && (byte_cnt == 3'h2);
  assign sw_allow = wp_s || !lock;

  // Level and lock bits change only through an allowed status write.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      level <= LEVEL_RESET;
      lock  <= LOCK_RESET;
    end else if (sw_hit && sw_allow) begin
      level <= status_data[ST_LEVEL_HI:ST_LEVEL_LO];
      lock  <= status_data[ST_LOCK];
    end
  end

  // Outcome pulses of a status write frame.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      STATUS_WRITE_DONE   <= 1'b0;
      STATUS_WRITE_REJECT <= 1'b0;
    end else begin
      STATUS_WRITE_DONE   <= sw_hit && sw_allow;
      STATUS_WRITE_REJECT <= sw_hit && !sw_allow;
    end
  end

  // Visible status byte.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      STATUS_REG <= 8'h00;
    end else begin
      STATUS_REG <= {lock, AAI_ACTIVE, level, WEL_IN, BUSY_IN};
    end
  end

  // Protected region runs from a power-of-two boundary to the array top.
  logic [23:0] prot_start;
  always_comb begin
    prot_start = 24'h000000;
    case (level[2:0])
      3'h1:    prot_start = 24'h000000 - ARRAY_TOP_SPAN * 24'h000040;
      default: prot_start = 24'h000000;
    endcase
    if (level[2:0] != 3'h0) begin
      prot_start = 24'h000000 - (ARRAY_TOP_SPAN << (level[2:0] - 3'h1));
      if (level[2:0] == 3'h7) begin
        prot_start = 24'h000000;
      end
    end
  end

  // Array protection flag; the region sits at the top of a 4 MByte space.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ADDR_PROTECTED <= 1'b1;
    end else begin
      ADDR_PROTECTED <= (level[2:0] != 3'h0) &&
                        ({2'b00, ADDR[21:0]} >= {2'b00, prot_start[21:0]});
    end
  end

  // ****************************************************************
  // Transmit path
  // ****************************************************************
  logic [7:0] tx_byte;
  logic       ryby_mode;
  assign ryby_mode = RYBY_ENABLE && AAI_ACTIVE;

  // Next byte to send is taken at each byte boundary.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      tx_byte <= 8'h00;
    end else if (cs_fall || byte_done) begin
      tx_byte <= TX_DATA;
    end
  end

  // Output level changes only on falling edges, or shows the inverse of busy in ready/busy mode.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      SO_OUT <= 1'b0;
    end else if (ryby_mode) begin
      SO_OUT <= !BUSY_IN;
    end else if (sck_fall) begin
      SO_OUT <= tx_byte[3'h7 - bit_pos];
    end
  end

  // Drive only when selected, not paused, and sending or in ready/busy mode.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      SO_OE_N <= 1'b1;
    end else begin
      SO_OE_N <= !(selected && (TX_ENABLE || ryby_mode));
    end
  end

  // Pause state made visible.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      PAUSED <= 1'b0;
    end else begin
      PAUSED <= pif.paused;
    end
  end

endmodule : serial_flash_spi_front_end

`default_nettype wire

// ### tb/flash_spi_asserts.sv
// Purpose: Port-level checks on the flash SPI front end.
// Assumes: Pins pass two synchroniser flops inside the design.
// Notes:   Bound to every instance of the front end.
`default_nettype none

module flash_spi_asserts
  import flash_spi_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic        CE_N,
  input wire logic        HOLD_N,
  input wire logic        RYBY_ENABLE,
  input wire logic        AAI_ACTIVE,
  input wire logic        BUSY_IN,
  input wire logic        SO_OUT,
  input wire logic        SO_OE_N,
  input wire logic [7:0]  RX_DATA,
  input wire logic        FRAME_ABORT,
  input wire logic        STATUS_WRITE_DONE,
  input wire logic        STATUS_WRITE_REJECT,
  input wire logic [7:0]  STATUS_REG,
  input wire logic [23:0] ADDR,
  input wire logic [23:0] SECTOR_BASE,
  input wire logic [23:0] BLOCK64_BASE,
  input wire logic        PAUSED
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Ready/busy mode held steady long enough for the synchronisers.
  sequence s_ryby_steady;
    (RYBY_ENABLE && AAI_ACTIVE && !CE_N && !PAUSED && $stable(BUSY_IN)) [*6];
  endsequence

  a_idle_float: assert property (CE_N [*8] |-> SO_OE_N)
    else $error("data-out driven while deselected");
  a_pause_float: assert property (PAUSED [*3] |-> SO_OE_N)
    else $error("data-out driven while paused");
  a_pause_entry: assert property ($rose(PAUSED) |-> !HOLD_N && !CE_N)
    else $error("pause entered without its cause");
  a_reject_keeps: assert property (STATUS_WRITE_REJECT |-> STATUS_REG[ST_LOCK]
    ##1 $stable({STATUS_REG[7], STATUS_REG[5:2]}) [*3])
    else $error("refused status write changed the register");
  a_done_loads: assert property (STATUS_WRITE_DONE |-> ##[1:2]
    (STATUS_REG[7] === RX_DATA[7] && STATUS_REG[5:2] === RX_DATA[5:2]))
    else $error("accepted status write not loaded");
  a_abort_nothing: assert property (FRAME_ABORT |->
    (!STATUS_WRITE_DONE && !STATUS_WRITE_REJECT) [*6])
    else $error("aborted frame committed a write");
  a_base_masks: assert property (SECTOR_BASE == ($past(ADDR) & SECTOR_MASK)
    && BLOCK64_BASE == ($past(ADDR) & BLOCK64_MASK))
    else $error("erase base not masked from address");
  a_ryby_level: assert property (s_ryby_steady |-> !SO_OE_N && SO_OUT == !BUSY_IN)
    else $error("ready/busy level wrong on data-out");

endmodule : flash_spi_asserts

bind serial_flash_spi_front_end flash_spi_asserts u_asserts (
  .REF_CLK, .RST_N, .CE_N, .HOLD_N, .RYBY_ENABLE, .AAI_ACTIVE, .BUSY_IN, .SO_OUT,
  .SO_OE_N, .RX_DATA, .FRAME_ABORT, .STATUS_WRITE_DONE, .STATUS_WRITE_REJECT,
  .STATUS_REG, .ADDR, .SECTOR_BASE, .BLOCK64_BASE, .PAUSED
);

`default_nettype wire

// ### tb/spi_master_model.sv
// Purpose: SPI bus master that frames and shifts bytes into the front end.
// Assumes: Serial clock half period of 32 ns, unrelated in phase to REF_CLK.
// Notes:   Data-in is inverted at deselect so a stale level never matches.
`default_nettype none

module spi_master_model (
  output logic      sck,
  output logic      ce_n,
  output logic      si,
  output logic      hold_n,
  input  wire logic so_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mode = 1'b0;

  // Idle bus: deselected, not paused.
  initial begin
    sck = 1'b0;
    ce_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end

  // Parks the clock at the idle level of the mode, then selects.
  task automatic select(input logic cpol);
    mode = cpol;
    sck = cpol;
    #64 ce_n = 1'b0;
    #64;
  endtask : select

  // Shifts n bits of d from bit top down; read data is caught at the rise.
  task automatic shift(input logic [7:0] d, input int top, input int n,
                       output logic [7:0] q);
    q = 8'h00;
    for (int i = top; i > top - n; i--) begin
      sck = 1'b0;
      si = d[i];
      #32 sck = 1'b1;
      q[i] = so_out;
      #32;
    end
  endtask : shift

  // Leaves the clock low, where pause edges take effect.
  task automatic park_low();
    sck = 1'b0;
    #64;
  endtask : park_low

  // Moves the pause pin only while selected or to leave a pause.
  task automatic hold(input logic lvl);
    hold_n = lvl;
    #64;
  endtask : hold

  // Ends the frame at the idle clock level, then lets data-in wander.
  task automatic deselect();
    sck = mode;
    #32 ce_n = 1'b1;
    si = ~si;
    #128;
  endtask : deselect

endmodule : spi_master_model

`default_nettype wire

// ### tb/testbench.sv
// Purpose: Drives status writes, pauses, ready/busy and address frames.
// Assumes: Write enable is not needed for status writes.
// Notes:   Result pulses are counted by a monitor and compared per frame.
`default_nettype none

module testbench
  import flash_spi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wp_n = 1'b1;
  logic        ryby_en = 1'b0;
  logic        auto_increment_program = 1'b0;
  logic        busy = 1'b0;
  logic        wel = 1'b0;
  logic        tx_en = 1'b1;
  logic [7:0]  tx_data = 8'hA5;
  logic        so_pin, rx_valid, fstart, fend, addr_prot;
  logic [2:0]  rx_index;
  logic [7:0]  addr_bytes [4] = '{8'h20, 8'h3F, 8'h9A, 8'hBC};
  logic        sck, ce_n, si, hold_n, so_out, so_oe_n, done, reject, abort, paused;
  logic [7:0]  rx_data, status, q;
  logic [23:0] addr, sector, blk32, blk64;
  logic [8:0]  tbl [4] = '{9'h19C, 9'h000, 9'h100, 9'h004};
  logic        lock = LOCK_RESET;
  logic [3:0]  lvl = LEVEL_RESET;
  int          n_done, n_rej, n_abort, nd, nr, na, mismatches, comparisons;
  int          n_rx, n_start, n_end, nrx, nst, nen;
  logic        ok;

  always #2.5 clk = ~clk;

  // A released data-out line shows the master the inverse of the last level.
  assign so_pin = so_oe_n ? !so_out : so_out;

  spi_master_model m (.sck, .ce_n, .si, .hold_n, .so_out(so_pin));

  serial_flash_spi_front_end dut (
    .REF_CLK(clk), .RST_N(rst_n), .SCK(sck), .CE_N(ce_n), .SI(si), .HOLD_N(hold_n),
    .WP_N(wp_n), .TX_DATA(tx_data), .TX_ENABLE(tx_en), .RYBY_ENABLE(ryby_en),
    .AAI_ACTIVE(auto_increment_program), .BUSY_IN(busy), .WEL_IN(wel), .SO_OUT(so_out), .SO_OE_N(so_oe_n),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_INDEX(rx_index), .FRAME_START(fstart),
    .FRAME_END(fend), .FRAME_ABORT(abort), .STATUS_WRITE_DONE(done),
    .STATUS_WRITE_REJECT(reject), .STATUS_REG(status), .ADDR(addr), .SECTOR_BASE(sector),
    .BLOCK32_BASE(blk32), .BLOCK64_BASE(blk64), .ADDR_PROTECTED(addr_prot), .PAUSED(paused)
  );

  // Counts the one-cycle result, byte and frame pulses.
  always @(posedge clk) begin
    if (done) n_done++;
    if (reject) n_rej++;
    if (abort) n_abort++;
    if (rx_valid) n_rx++;
    if (fstart) n_start++;
    if (fend) n_end++;
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input logic good, input string what);
    comparisons++;
    if (good !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : check

  // Sends a whole two-byte status write frame.
  task automatic wr_status(input logic cpol, input logic [7:0] d);
    m.select(cpol);
    m.shift(OP_STATUS_WRITE, 7, 8, q);
    m.shift(d, 7, 8, q);
    m.deselect();
  endtask : wr_status

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // Cuts a hang short well past the expected run length.
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(status[7] === lock && status[5:2] === lvl, "status reset value");
    for (int k = 0; k < 8; k++) begin
      @(posedge clk) wp_n <= tbl[k % 4][8];
      nd = n_done;
      nr = n_rej;
      ok = tbl[k % 4][8] | ~lock;
      wr_status(k[2], tbl[k % 4][7:0]);
      check(n_done == nd + ok && n_rej == nr + !ok, "status write verdict");
      if (ok) begin
        lock = tbl[k % 4][7];
        lvl = tbl[k % 4][5:2];
      end
      check(status[7] === lock && status[5:2] === lvl, "status register");
      if (k[2]) check(q === 8'hA5, "data-out byte");
    end
    nd = n_done;
    na = n_abort;
    m.select(1'b0);
    m.shift(OP_STATUS_WRITE, 7, 8, q);
    m.shift(8'h00, 7, 3, q);
    m.deselect();
    check(n_abort == na + 1 && n_done == nd && status[5:2] === lvl, "abort");
    @(posedge clk) wp_n <= 1'b1;
    m.select(1'b0);
    m.shift(OP_STATUS_WRITE, 7, 8, q);
    m.shift(8'h98, 7, 3, q);
    m.hold(1'b0);
    check(paused === 1'b0, "pause before clock low");
    m.park_low();
    check(paused === 1'b1 && so_oe_n === 1'b1, "paused and floating");
    m.shift(8'h67, 4, 3, q);
    m.park_low();
    m.hold(1'b1);
    check(paused === 1'b0, "resume");
    m.shift(8'h98, 4, 5, q);
    m.deselect();
    check(status[7] === 1'b1 && status[5:2] === 4'h6, "bits kept over pause");
    m.select(1'b0);
    m.shift(OP_STATUS_WRITE, 7, 4, q);
    m.park_low();
    m.hold(1'b0);
    m.deselect();
    check(paused === 1'b1, "pause outlives deselect");
    m.hold(1'b1);
    check(paused === 1'b0 && status[7] === 1'b1, "standby after pause");
    @(posedge clk) begin
      ryby_en <= 1'b1;
      auto_increment_program <= 1'b1;
      busy <= 1'b1;
      wel <= 1'b1;
    end
    m.select(1'b0);
    check(so_oe_n === 1'b0 && so_out === 1'b0, "busy shown");
    @(posedge clk) busy <= 1'b0;
    repeat (8) @(posedge clk);
    check(so_out === 1'b1, "ready shown");
    check(status[1] === 1'b1 && status[6] === 1'b1 && status[0] === 1'b0, "status flags");
    m.deselect();
    check(so_oe_n === 1'b1, "float when deselected");
    @(posedge clk) begin
      ryby_en <= 1'b0;
      tx_en <= 1'b0;
    end
    nrx = n_rx;
    nst = n_start;
    nen = n_end;
    m.select(1'b1);
    foreach (addr_bytes[i]) m.shift(addr_bytes[i], 7, 8, q);
    m.deselect();
    check(addr === 24'h3F9ABC && sector === (24'h3F9ABC & SECTOR_MASK), "address");
    check(blk32 === 24'h3F8000 && blk64 === 24'h3F0000, "erase blocks");
    check(q === ~tx_data, "data-out released when not sending");
    check(n_rx == nrx + 4 && rx_index === 3'h3 && rx_data === 8'hBC, "received bytes");
    check(n_start == nst + 1 && n_end == nen + 1, "frame start and end");
    check(addr_prot === 1'b1, "address in protected upper half");
    give_verdict();
  end

endmodule : testbench

`default_nettype wire
